// file: tb/sd_gear_sva.sv
// Port-level checks for the step/direction gearing block.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sd_gear_sva (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       step_input_pin,
  input wire logic       internal_gen_en,
  input wire logic       internal_step,
  input wire logic [7:0] sine_table_jump,
  input wire logic       handover
);
  // Previous raw step level
  logic       pin_d_r;
  // Cycles since the step pin last moved; saturates so it never wraps
  logic [3:0] since_r;
  // Age counter lets one check bound the whole sync and gearing pipeline
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_d_r <= 1'b0;
      since_r <= 4'hf;
    end else begin
      pin_d_r <= step_input_pin;
      if (step_input_pin != pin_d_r) since_r <= 4'h0;
      else if (since_r != 4'hf) since_r <= since_r + 4'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_step_from_pin: assert property (internal_step |-> since_r inside {[2:8]})
    else $error("step without pin edge");
  a_step_ext_only: assert property (internal_step |-> !internal_gen_en)
    else $error("step with generator on");
  a_jump_on_step: assert property (internal_step |-> sine_table_jump != 8'h00)
    else $error("zero jump on step");
  a_jump_idle_zero: assert property (!internal_step |-> sine_table_jump == 8'h00)
    else $error("jump without step");
  a_handover_pulse: assert property (handover |=> !handover)
    else $error("handover too long");
  a_handover_gen_on: assert property (handover |-> ##[0:2] internal_gen_en)
    else $error("generator off at handover");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bvalid not held");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("rvalid not held");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_latency: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
    else $error("write answer late");
  c_burst: cover property (internal_step && sine_table_jump > 8'h01);
  c_handover: cover property (handover);
  c_refused: cover property (s_axi_bvalid && s_axi_bresp == sd_gear_pkg::RESP_SLVERR);
endmodule
`default_nettype wire

// file: tb/step_source.sv
// Upstream controller model: step pulses with a direction.
// Assumes send() runs from one process, just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module step_source (
  input  wire logic aclk,
  output var  logic step_input_pin,
  output var  logic direction_input_pin
);
  // Step line idles low between bursts
  initial begin
    step_input_pin = 1'b0;
    direction_input_pin = 1'b0;
  end
  // Pulse high then low for gap cycles each; indirect mode needs 64 or more
  task automatic send(input int n, input logic dir, input int gap);
    direction_input_pin <= dir;
    repeat (gap) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      step_input_pin <= 1'b1;
      repeat (gap) @(posedge aclk);
      step_input_pin <= 1'b0;
      repeat (gap) @(posedge aclk);
    end
  endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench: AXI4-Lite registers, steps from a source model.
// Assumes package, design, model and checker compile first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned AW = 10;
  localparam int LIMIT = 20000; // Whole run needs under a thousand cycles
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, step_input_pin, direction_input_pin, internal_gen_en;
  logic internal_step, internal_step_neg, handover, last_neg = 0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, v;
  logic [3:0]  s_axi_wstrb = 4'hf; // Whole words only
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  sine_table_jump, last_jump = '0;
  logic [7:0]  regs [8] = '{sd_gear_pkg::IDX_GENERAL_CONFIGURATION,
    sd_gear_pkg::IDX_GEARING_FACTOR, sd_gear_pkg::IDX_START_VELOCITY,
    sd_gear_pkg::IDX_START_ACCELERATION, sd_gear_pkg::IDX_CURRENT_POSITION,
    sd_gear_pkg::IDX_TARGET_POSITION, sd_gear_pkg::IDX_CURRENT_VELOCITY,
    sd_gear_pkg::IDX_CURRENT_ACCELERATION};
  int err_count = 0, checks = 0, cyc = 0, step_cnt = 0, ho_cnt = 0, h;
  logic [31:0] exp_pos = '0;
  initial forever #5 aclk = ~aclk;
  step_dir_input_gearing #(.ADDR_W(AW)) u_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .step_input_pin, .direction_input_pin, .internal_gen_en,
    .internal_step, .internal_step_neg, .sine_table_jump, .handover);
  step_source u_src (.aclk, .step_input_pin, .direction_input_pin);
  // Record step bursts and handovers; cut a hang short
  always @(posedge aclk) begin
    if (internal_step) begin
      step_cnt <= step_cnt + 1;
      last_jump <= sine_table_jump;
      last_neg <= internal_step_neg;
    end
    if (handover) ho_cnt <= ho_cnt + 1;
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Write one word, both channels offered at once
  task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                    input logic [1:0] er = sd_gear_pkg::RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= AW'({idx, 2'b00});
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                    input logic [1:0] er = sd_gear_pkg::RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= AW'({idx, 2'b00});
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask
  task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    rd(idx, x);
    chk($sformatf("reg_%h", idx), exp, x);
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] m, input logic p, input logic i,
                                      input logic a);
    cfg = (32'(m) << sd_gear_pkg::GC_MODE_LO) | (32'(p) << sd_gear_pkg::GC_POL_DIR)
        | (32'(i) << sd_gear_pkg::GC_INDIRECT) | (32'(a) << sd_gear_pkg::GC_AUTO_OFF);
  endfunction
  // Send pulses, then compare the position with the running expectation
  task automatic mv(input int n, input logic dir, input int dp);
    u_src.send(n, dir, 8);
    exp_pos = exp_pos + 32'(dp);
    rc(regs[4], exp_pos);
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) rc(regs[i], sd_gear_pkg::RST_WORD);
    for (int i = 1; i < 4; i++) begin
      wr(regs[i], 32'ha5c3_0000 | 32'(i));
      rc(regs[i], 32'ha5c3_0000 | 32'(i));
    end
    rd(8'h3f, v, sd_gear_pkg::RESP_SLVERR);
    wr(regs[4], 32'h0000_0001, sd_gear_pkg::RESP_SLVERR);
    wr(regs[1], 32'h0100_0000);
    wr(regs[0], cfg(2'h1, 0, 0, 0));
    // The enable output settles one edge after the register lands
    @(posedge aclk);
    chk("gen_en", 32'h0, 32'(internal_gen_en));
    mv(3, 1'b1, 3);
    wr(regs[0], cfg(2'h2, 0, 0, 0));
    mv(2, 1'b1, 2);
    wr(regs[0], cfg(2'h3, 0, 0, 0));
    mv(2, 1'b1, 4);
    wr(regs[0], cfg(2'h1, 0, 0, 0));
    mv(2, 1'b0, -2);
    wr(regs[0], cfg(2'h1, 1, 0, 0));
    mv(1, 1'b0, 1);
    wr(regs[1], 32'hff00_0000);
    mv(1, 1'b0, -1);
    chk("step_neg", 32'h1, 32'(last_neg));
    wr(regs[0], cfg(2'h1, 0, 0, 0));
    wr(regs[1], 32'h0080_0000);
    h = step_cnt;
    mv(3, 1'b1, 1);
    chk("bursts", 32'h1, 32'(step_cnt - h));
    wr(regs[1], 32'h0280_0000);
    mv(1, 1'b1, 3);
    chk("jump", 32'h3, 32'(last_jump));
    wr(regs[1], 32'h7f00_0000);
    mv(1, 1'b1, 127);
    chk("jump", 32'h7f, 32'(last_jump));
    wr(regs[1], 32'h0100_0000);
    rc(regs[6], 32'h0);
    wr(regs[2], 32'h0000_1234);
    wr(regs[0], cfg(2'h1, 0, 0, 1));
    mv(1, 1'b1, 1);
    rc(regs[6], 32'h0000_1234);
    wr(regs[3], 32'h8000_0010);
    h = ho_cnt;
    wr(regs[0], cfg(2'h0, 0, 0, 1));
    repeat (4) @(posedge aclk);
    chk("handovers", 32'h1, 32'(ho_cnt - h));
    chk("gen_en", 32'h1, 32'(internal_gen_en));
    rc(regs[6], 32'h0000_1234);
    rc(regs[7], 32'hffff_fff0);
    wr(regs[0], cfg(2'h1, 0, 1, 0));
    rc(regs[5], sd_gear_pkg::RST_WORD);
    u_src.send(2, 1'b1, sd_gear_pkg::MIN_STEP_GAP_CYC);
    rc(regs[5], 32'h2);
    rc(regs[4], exp_pos);
    wr(regs[3], 32'h0);
    wr(regs[0], cfg(2'h1, 0, 0, 1));
    wr(regs[0], cfg(2'h0, 0, 0, 1));
    rc(regs[7], 32'h0);
    summarize();
  end
endmodule
bind step_dir_input_gearing sd_gear_sva u_sva (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .step_input_pin, .internal_gen_en, .internal_step, .sine_table_jump, .handover);
`default_nettype wire

// file: verilog/gear_accumulator.sv
// Electronic gearing accumulator: adds the factor per external step and
// reports how many internal steps overflowed out of the fraction into the integer part.
// Assumes one external step per cycle at most.
`timescale 1ns/1ps
`default_nettype none
module gear_accumulator #(
  parameter int unsigned FRAC = 24
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    step_in,
  input  wire logic                    dir_neg_in,
  input  wire logic [31:0]             factor,
  output var  sd_gear_pkg::gear_step_t result
);
  initial begin
    if (FRAC != 24) $error("gear_accumulator supports FRAC of 24 only");
  end
  logic [FRAC-1:0] frac_r;               // Kept remainder
  wire             fneg  = factor[31];
  // Magnitude of the factor, 7 integer bits plus fraction
  wire [31:0]      fmag  = fneg ? (~factor + 32'h0000_0001) : factor;
  wire [32:0]      sum   = {9'h000, frac_r} + {1'b0, fmag};
  // Negative factor flips the pin-derived direction
  wire             neg   = dir_neg_in ^ fneg;  // see (R10)

  // Accumulate magnitude; integer part is the burst of internal steps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frac_r <= '0;
      result <= '0;
    end else if (step_in) begin
      frac_r       <= sum[FRAC-1:0];      // see (R7)
      result.valid <= 1'b1;
      result.neg   <= neg;
      result.count <= sum[FRAC+7:FRAC];   // see (R7) (R8) (R9)
    end else begin
      result.valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: verilog/sd_gear_pkg.sv
// Shared constants and carriers for the external step/direction gearing block.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register slave.
package sd_gear_pkg;
  // Clock rate in MHz
  localparam int unsigned CLK_MHZ = 100;
  // Printed register offsets are word indices; byte address is four times each
  localparam logic [7:0] IDX_GENERAL_CONFIGURATION = 8'h00;
  localparam logic [7:0] IDX_GEARING_FACTOR        = 8'h12;
  localparam logic [7:0] IDX_START_VELOCITY        = 8'h25;
  localparam logic [7:0] IDX_START_ACCELERATION    = 8'h2a;
  localparam logic [7:0] IDX_CURRENT_POSITION      = 8'h40;
  localparam logic [7:0] IDX_TARGET_POSITION       = 8'h41;
  localparam logic [7:0] IDX_CURRENT_VELOCITY      = 8'h42;
  localparam logic [7:0] IDX_CURRENT_ACCELERATION  = 8'h43;
  localparam logic [7:0] IDX_STATUS                = 8'h44;
  // Field positions inside general_configuration
  localparam int unsigned GC_MODE_LO      = 6;
  localparam int unsigned GC_POL_DIR      = 8;
  localparam int unsigned GC_INDIRECT     = 9;
  localparam int unsigned GC_AUTO_OFF     = 26;
  // Gearing fixed point: 8 integer bits, 24 fraction bits
  localparam int unsigned GEAR_FRAC_BITS  = 24;
  // Least spacing of external steps in indirect mode, in clock cycles
  localparam int unsigned MIN_STEP_GAP_CYC = 64;
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Step input mode encodings
  typedef enum logic [1:0] {
    MODE_OFF    = 2'b00,
    MODE_RISE   = 2'b01,
    MODE_FALL   = 2'b10,
    MODE_TOGGLE = 2'b11
  } step_mode_t;

  // Configuration carried to the gearing logic
  typedef struct packed {
    step_mode_t  mode;
    logic        pol_dir;
    logic        indirect;
    logic        auto_off;
  } gear_cfg_t;

  // One gearing result per external step
  typedef struct packed {
    logic        valid;
    logic        neg;
    logic [7:0]  count;
  } gear_step_t;
endpackage

// file: verilog/step_dir_input_gearing.sv
// External step/direction input with electronic gearing, direct and
// indirect position control, and external to internal ramp handover.
// Assumes an AXI4-Lite master and one 100 MHz clock.
// Notes on behaviour
// (R1) Mode 01 counts step pin rising edges
// (R2) Mode 10 counts step pin falling edges
// (R3) Mode 11 counts both step edges
// (R4) Any external mode disables internal steps
// (R5) Direction pin low is negative unless inverted
// (R6) Gearing factor is signed 8.24 value
// (R7) Accumulate factor; overflow gives internal step
// (R8) Factor magnitude from 2^-24 to 127
// (R9) Large overflow gives back-to-back steps, table jumps
// (R10) Negative factor inverts derived direction
// (R11) Direct mode forces velocity zero without preset
// (R12) Preset loads start velocity with step direction
// (R13) Indirect mode moves target by one
// (R14) Source spaces indirect steps 64 cycles apart
// (R15) Leaving external mode starts ramp at start velocity
// (R16) Handover acceleration sign from bit 31
// (R17) Host zeroes start acceleration for plain handover
// (R18) Host keeps start velocity updated
// (R19) Host sets switch-off bit before leaving
// (R20) Synchronise pins, detect edges from samples
`timescale 1ns/1ps
`default_nettype none
module step_dir_input_gearing #(
  parameter int unsigned ADDR_W = 10
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Pins
  input  wire logic              step_input_pin,
  input  wire logic              direction_input_pin,
  // Motion state towards the driver side
  output var  logic              internal_gen_en,
  output var  logic              internal_step,
  output var  logic              internal_step_neg,
  output var  logic [7:0]        sine_table_jump,
  output var  logic              handover
);
  initial begin
    if (ADDR_W < 9) $error("ADDR_W must reach word index 0x44");
  end

  // Register file
  logic [31:0] general_configuration_r;  // Mode, polarity, indirect, switch-off
  logic [31:0] gearing_factor_r;         // Signed 8.24 factor, see (R6)
  logic [31:0] start_velocity_r;         // Velocity preset / handover speed
  logic [31:0] start_acceleration_r;     // Sign-magnitude handover acceleration
  logic [31:0] current_position_r;       // Position counter
  logic [31:0] target_position_r;        // Ramp target
  logic [31:0] current_velocity_r;       // Internal ramp velocity
  logic [31:0] current_acceleration_r;   // Internal ramp acceleration
  logic        last_neg_r;               // Direction of latest external step
  logic [31:0] since_step_r;             // Cycles since the last external step
  logic [31:0] handover_gap_r;           // Step timing captured at handover
  logic        was_ext_r;                // External mode seen last cycle

  // Configuration decode
  sd_gear_pkg::gear_cfg_t cfg;
  assign cfg.mode     = sd_gear_pkg::step_mode_t'(
                          general_configuration_r[sd_gear_pkg::GC_MODE_LO +: 2]);
  assign cfg.pol_dir  = general_configuration_r[sd_gear_pkg::GC_POL_DIR];
  assign cfg.indirect = general_configuration_r[sd_gear_pkg::GC_INDIRECT];
  assign cfg.auto_off = general_configuration_r[sd_gear_pkg::GC_AUTO_OFF];
  wire ext_on     = (cfg.mode != sd_gear_pkg::MODE_OFF);
  wire direct_on  = ext_on & ~cfg.indirect;
  wire preset_on  = direct_on & cfg.auto_off;

  // Edge detection and gearing
  logic step_seen;
  logic dir_level;
  sd_gear_pkg::gear_step_t gres;
  step_edge_detect u_edge (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .mode                (cfg.mode),
    .step_input_pin      (step_input_pin),
    .direction_input_pin (direction_input_pin),
    .step_seen           (step_seen),
    .dir_level           (dir_level)
  );
  // Pin low means negative unless polarity bit set
  wire dir_neg = dir_level ~^ cfg.pol_dir;  // see (R5)
  gear_accumulator #(.FRAC(sd_gear_pkg::GEAR_FRAC_BITS)) u_gear (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .step_in    (step_seen),
    .dir_neg_in (dir_neg),
    .factor     (gearing_factor_r),
    .result     (gres)
  );
  wire        gstep   = gres.valid & (gres.count != 8'h00);
  wire [31:0] gdelta  = gres.neg ? (32'h0 - {24'h0, gres.count}) : {24'h0, gres.count};
  wire [31:0] one_sgn = gres.neg ? 32'hffff_ffff : 32'h0000_0001;
  wire        leaving = was_ext_r & ~ext_on & cfg.auto_off;
  wire [31:0] vel_sgn = last_neg_r ? (32'h0 - start_velocity_r) : start_velocity_r;
  wire [31:0] acc_mag = {1'b0, start_acceleration_r[30:0]};
  wire [31:0] acc_sgn = start_acceleration_r[31] ? (32'h0 - acc_mag) : acc_mag;

  // AXI4-Lite write channel: take address and data in either order
  logic [ADDR_W-1:0] aw_r;
  logic              aw_have_r;
  logic [31:0]       w_r;
  logic [3:0]        ws_r;
  logic              w_have_r;
  wire               do_write = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire [7:0]         widx = 8'(aw_r[ADDR_W-1:2]);
  wire [7:0]         ridx = 8'(s_axi_araddr[ADDR_W-1:2]);
  wire               wr_gc = do_write & (widx == sd_gear_pkg::IDX_GENERAL_CONFIGURATION);
  wire               wr_gf = do_write & (widx == sd_gear_pkg::IDX_GEARING_FACTOR);
  wire               wr_sv = do_write & (widx == sd_gear_pkg::IDX_START_VELOCITY);
  wire               wr_sa = do_write & (widx == sd_gear_pkg::IDX_START_ACCELERATION);
  wire               wr_tp = do_write & (widx == sd_gear_pkg::IDX_TARGET_POSITION);
  wire               wr_ok = wr_gc | wr_gf | wr_sv | wr_sa | wr_tp;

  // Byte-lane merge for a written register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) m[8*b +: 8] = d[8*b +: 8];
    end
    return m;
  endfunction

  // Address and data holding; ready is high while the slot is free
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_r          <= '0;
      w_r           <= sd_gear_pkg::RST_WORD;
      ws_r          <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= sd_gear_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_have_r & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_have_r & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_r      <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_r <= 1'b1;
        w_r      <= s_axi_wdata;
        ws_r     <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? sd_gear_pkg::RESP_OKAY : sd_gear_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one read at a time, answered the cycle after acceptance
  logic [31:0] rmux;
  logic        rhit;
  always_comb begin
    rhit = 1'b1;
    case (ridx)
      sd_gear_pkg::IDX_GENERAL_CONFIGURATION: rmux = general_configuration_r;
      sd_gear_pkg::IDX_GEARING_FACTOR:        rmux = gearing_factor_r;
      sd_gear_pkg::IDX_START_VELOCITY:        rmux = start_velocity_r;
      sd_gear_pkg::IDX_START_ACCELERATION:    rmux = start_acceleration_r;
      sd_gear_pkg::IDX_CURRENT_POSITION:      rmux = current_position_r;
      sd_gear_pkg::IDX_TARGET_POSITION:       rmux = target_position_r;
      sd_gear_pkg::IDX_CURRENT_VELOCITY:      rmux = current_velocity_r;
      sd_gear_pkg::IDX_CURRENT_ACCELERATION:  rmux = current_acceleration_r;
      sd_gear_pkg::IDX_STATUS:                rmux = {29'h0, last_neg_r, ext_on, handover};
      default: begin
        rmux = sd_gear_pkg::RST_WORD;
        rhit = 1'b0;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= sd_gear_pkg::RST_WORD;
      s_axi_rresp   <= sd_gear_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rmux;
        s_axi_rresp  <= rhit ? sd_gear_pkg::RESP_OKAY : sd_gear_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Writable configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      general_configuration_r <= sd_gear_pkg::RST_WORD;
      gearing_factor_r        <= sd_gear_pkg::RST_WORD;
      start_velocity_r        <= sd_gear_pkg::RST_WORD;
      start_acceleration_r    <= sd_gear_pkg::RST_WORD;
    end else begin
      if (wr_gc) general_configuration_r <= merge(general_configuration_r, w_r, ws_r);
      if (wr_gf) gearing_factor_r        <= merge(gearing_factor_r, w_r, ws_r);
      if (wr_sv) start_velocity_r        <= merge(start_velocity_r, w_r, ws_r);
      if (wr_sa) start_acceleration_r    <= merge(start_acceleration_r, w_r, ws_r);
    end
  end

  // Position and target: direct mode moves position, indirect the target.
  // Indirect updates rely on the source's step spacing, see (R14).
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      current_position_r <= sd_gear_pkg::RST_WORD;
      target_position_r  <= sd_gear_pkg::RST_WORD;
    end else begin
      if (gstep & direct_on) current_position_r <= current_position_r + gdelta;  // see (R7)
      // A step beats a host write to the target in the same cycle
      if (gres.valid & cfg.indirect & ext_on & gstep) begin
        target_position_r <= target_position_r + one_sgn;                     // see (R13)
      end else if (wr_tp) begin
        target_position_r <= merge(target_position_r, w_r, ws_r);
      end
    end
  end

  // Ramp velocity and acceleration seen by the rest of the chip
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      current_velocity_r     <= sd_gear_pkg::RST_WORD;
      current_acceleration_r <= sd_gear_pkg::RST_WORD;
      handover_gap_r         <= sd_gear_pkg::RST_WORD;
    end else if (leaving) begin
      current_velocity_r     <= vel_sgn;           // see (R15)
      current_acceleration_r <= acc_sgn;           // see (R16)
      handover_gap_r         <= since_step_r;      // see (R15)
    end else if (preset_on) begin
      current_velocity_r     <= vel_sgn;           // see (R12)
    end else if (direct_on) begin
      current_velocity_r     <= sd_gear_pkg::RST_WORD;  // see (R11)
    end
  end

  // Step direction memory, step timing and mode tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_neg_r   <= 1'b0;
      since_step_r <= sd_gear_pkg::RST_WORD;
      was_ext_r    <= 1'b0;
    end else begin
      was_ext_r <= ext_on;
      if (gstep) begin
        last_neg_r   <= gres.neg;
        since_step_r <= sd_gear_pkg::RST_WORD;
      end else if (since_step_r != 32'hffff_ffff) begin
        since_step_r <= since_step_r + 32'h0000_0001;
      end
    end
  end

  // Registered outputs to the driver side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      internal_gen_en   <= 1'b1;
      internal_step     <= 1'b0;
      internal_step_neg <= 1'b0;
      sine_table_jump   <= 8'h00;
      handover          <= 1'b0;
    end else begin
      internal_gen_en   <= ~ext_on;                                 // see (R4)
      internal_step     <= gstep & direct_on;
      internal_step_neg <= gres.neg;
      sine_table_jump   <= (gstep & direct_on) ? gres.count : 8'h00; // see (R9)
      handover          <= leaving;
    end
  end
endmodule
`default_nettype wire

// file: verilog/step_edge_detect.sv
// Synchroniser and step edge detector for the step and direction pins.
// Assumes the pins change slowly against the system clock.
`timescale 1ns/1ps
`default_nettype none
module step_edge_detect (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire sd_gear_pkg::step_mode_t mode,
  input  wire logic                  step_input_pin,
  input  wire logic                  direction_input_pin,
  output var  logic                  step_seen,
  output var  logic                  dir_level
);
  logic [1:0] stp_sync_r;  // Two stage step synchroniser
  logic [1:0] dir_sync_r;  // Two stage direction synchroniser
  logic       stp_last_r;  // Previous synchronised step level
  wire        rise = stp_sync_r[1] & ~stp_last_r;
  wire        fall = ~stp_sync_r[1] & stp_last_r;

  // Only the second stage is looked at, never the first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stp_sync_r <= 2'h0;
      dir_sync_r <= 2'h0;
      stp_last_r <= 1'b0;
    end else begin
      stp_sync_r <= {stp_sync_r[0], step_input_pin};       // see (R20)
      dir_sync_r <= {dir_sync_r[0], direction_input_pin};  // see (R20)
      stp_last_r <= stp_sync_r[1];
    end
  end

  // Edge selection per mode
  always_comb begin
    case (mode)
      sd_gear_pkg::MODE_RISE:   step_seen = rise;         // see (R1)
      sd_gear_pkg::MODE_FALL:   step_seen = fall;         // see (R2)
      sd_gear_pkg::MODE_TOGGLE: step_seen = rise | fall;  // see (R3)
      default:                  step_seen = 1'b0;
    endcase
  end
  assign dir_level = dir_sync_r[1];
endmodule
`default_nettype wire
